// [design/atr_consts.vh]
// atr_consts.vh: register map, field positions, reset values and trigger codes
// for the converter trigger and result-format block; definitions only
`ifndef ATR_CONSTS_VH
`define ATR_CONSTS_VH

// register byte offsets (aligned words on the 32-bit bus)
`define ATR_OFF_TRIG_SEL      12'h000
`define ATR_OFF_RES_HIGH      12'h004
`define ATR_OFF_RES_LOW       12'h008
`define ATR_OFF_CONV_CTRL     12'h00C
`define ATR_OFF_CONV_DATA     12'h010

// field positions
`define ATR_TRIG_SEL_MSB      3
`define ATR_CTRL_BUSY_BIT     0
`define ATR_CTRL_JUSTIFY_BIT  1

// reset values
`define ATR_TRIG_SEL_RST      4'h0
`define ATR_JUSTIFY_RST       1'b0

// trigger select codes
`define ATR_TRIG_NONE         4'h0
`define ATR_TRIG_TMR0_OVF     4'h3
`define ATR_TRIG_TMR1_OVF     4'h4
`define ATR_TRIG_TMR2_PER     4'h5
`define ATR_TRIG_CMP1         4'h6
`define ATR_TRIG_CMP2         4'h7
`define ATR_TRIG_LC1          4'h8
`define ATR_TRIG_LC2          4'h9
`define ATR_TRIG_CC1          4'hC
`define ATR_TRIG_CC2          4'hD

// ahb transfer type
`define ATR_HTRANS_NONSEQ_BIT 1

`endif

// [design/atr_trigger_result.v]
// atr_trigger_result.v: converter start trigger selection and result formatting
// with an ahb-lite register slave.
// assumes a converter core that takes conv_start_o and returns conv_done_i with the
// 10-bit value on conv_value_i; trigger inputs are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "atr_consts.vh"

// Behaviour
// - The 4-bit trigger select field sits in bits 3..0 and code 0000 disables automatic starts.
// - Codes 1101 and 1100 route capture/compare unit two and one events to the start logic.
// - Codes 1001 and 1000 route logic cell two and one outputs to the start logic.
// - Codes 0111/0110 pick comparator two/one, 0101 timer-two period, 0100/0011 timer one/zero overflow.
// - The selected source is detected on its rising edge only, so a held level starts one conversion.
// - Left justified, result bits 9..2 fill the high result register.
// - Left justified, result bits 1..0 sit in low register bits 7..6 and bits 5..0 are zero.
// - Right justified, result bits 9..8 sit in high register bits 1..0 and bits 7..2 are zero.
// - Right justified, result bits 7..0 fill the low result register.
// - Result registers are writable, not reset, and the trigger select field clears on reset.
// - The justify bit set means right justified, clear means left justified.
// - Setting the busy flag starts a conversion and hardware clears it when it finishes.
module atr_trigger_result (
    input  wire        clk_i,          // system clock, 100 MHz
    input  wire        rst_b_i,        // asynchronous reset, active low
    input  wire        hsel_i,         // slave select
    input  wire [11:0] haddr_i,        // byte address
    input  wire [1:0]  htrans_i,       // transfer type
    input  wire        hwrite_i,       // write when high
    input  wire [2:0]  hsize_i,        // transfer size
    input  wire [31:0] hwdata_i,       // write data
    input  wire        hready_i,       // bus ready in
    output reg  [31:0] hrdata_o,       // read data
    output reg         hreadyout_o,    // slave ready
    output reg         hresp_o,        // always okay
    input  wire        tmr0_ovf_i,     // timer zero overflow flag
    input  wire        tmr1_ovf_i,     // timer one overflow flag
    input  wire        tmr2_per_i,     // timer two period match flag
    input  wire        cmp1_i,         // comparator one output
    input  wire        cmp2_i,         // comparator two output
    input  wire        lc1_i,          // logic cell one output
    input  wire        lc2_i,          // logic cell two output
    input  wire        cc1_i,          // capture/compare one event
    input  wire        cc2_i,          // capture/compare two event
    input  wire        conv_done_i,    // converter finished, one-cycle pulse
    input  wire [9:0]  conv_value_i,   // conversion_result from the converter
    output reg         conv_start_o,   // start pulse to the converter
    output reg         conv_busy_o     // conversion in progress
);

    // ****************************************************************
    // functions
    // ****************************************************************
    // level of the source that a trigger code names; unused codes pick nothing
    function src_pick;
        input [3:0] code;
        input [8:0] src;
        begin
            case (code)
                `ATR_TRIG_TMR0_OVF: src_pick = src[0];
                `ATR_TRIG_TMR1_OVF: src_pick = src[1];
                `ATR_TRIG_TMR2_PER: src_pick = src[2];
                `ATR_TRIG_CMP1:     src_pick = src[3];
                `ATR_TRIG_CMP2:     src_pick = src[4];
                `ATR_TRIG_LC1:      src_pick = src[5];
                `ATR_TRIG_LC2:      src_pick = src[6];
                `ATR_TRIG_CC1:      src_pick = src[7];
                `ATR_TRIG_CC2:      src_pick = src[8];
                default:            src_pick = 1'b0;
            endcase
        end
    endfunction

    // true when a data phase writes the register at the given offset
    function wr_hit;
        input        valid;
        input        write;
        input [11:0] addr;
        input [11:0] offset;
        begin
            wr_hit = valid & write & (addr == offset);
        end
    endfunction

    // high result byte of a finished conversion in the chosen layout
    function [7:0] fmt_high;
        input       right;
        input [9:0] value;
        begin
            if (right) begin
                fmt_high = {6'h00, value[9:8]};
            end else begin
                fmt_high = value[9:2];
            end
        end
    endfunction

    // low result byte of a finished conversion in the chosen layout
    function [7:0] fmt_low;
        input       right;
        input [9:0] value;
        begin
            if (right) begin
                fmt_low = value[7:0];
            end else begin
                fmt_low = {value[1:0], 6'h00};
            end
        end
    endfunction

    // read view of one byte offset; unmapped offsets read zero
    function [31:0] rd_view;
        input [11:0] addr;
        input [3:0]  sel;
        input [7:0]  high;
        input [7:0]  low;
        input        right;
        input        busy;
        begin
            case (addr)
                `ATR_OFF_TRIG_SEL:  rd_view = {28'h0, sel};
                `ATR_OFF_RES_HIGH:  rd_view = {24'h0, high};
                `ATR_OFF_RES_LOW:   rd_view = {24'h0, low};
                `ATR_OFF_CONV_CTRL: rd_view = {30'h0, right, busy};
                `ATR_OFF_CONV_DATA: rd_view = {22'h0, high[1:0], low};
                default:            rd_view = 32'h0000_0000;
            endcase
        end
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    reg  [3:0]  trig_sel_r;
    reg  [3:0]  trig_sel_nxt;
    reg         justify_r;
    reg         justify_nxt;
    reg  [7:0]  res_high_r;
    reg  [7:0]  res_high_nxt;
    reg  [7:0]  res_low_r;
    reg  [7:0]  res_low_nxt;
    reg         src_prev_r;
    reg         dp_valid_r;
    reg         dp_write_r;
    reg  [11:0] dp_addr_r;
    reg  [31:0] rd_nxt;
    reg         busy_nxt;
    reg         start_nxt;
    wire [8:0]  src_vec;
    wire        src_now;
    wire        trig_edge;
    wire        addr_phase;
    wire        wr_sel;
    wire        wr_ctrl;
    wire        wr_high;
    wire        wr_low;
    wire        sw_go;
    wire        start_now;
    wire        conv_load;

    // ****************************************************************
    // trigger source selection and edge detection
    // ****************************************************************
    assign src_vec   = {cc2_i, cc1_i, lc2_i, lc1_i, cmp2_i, cmp1_i,
                        tmr2_per_i, tmr1_ovf_i, tmr0_ovf_i};
    assign src_now   = src_pick(trig_sel_r, src_vec);
    // previous level resets low, the idle level of every source
    assign trig_edge = src_now & ~src_prev_r;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            src_prev_r <= 1'b0;
        end else begin
            src_prev_r <= src_now;
        end
    end

    // ****************************************************************
    // bus decode
    // ****************************************************************
    assign addr_phase = hsel_i & hready_i & htrans_i[`ATR_HTRANS_NONSEQ_BIT];
    assign wr_sel     = wr_hit(dp_valid_r, dp_write_r, dp_addr_r, `ATR_OFF_TRIG_SEL);
    assign wr_ctrl    = wr_hit(dp_valid_r, dp_write_r, dp_addr_r, `ATR_OFF_CONV_CTRL);
    assign wr_high    = wr_hit(dp_valid_r, dp_write_r, dp_addr_r, `ATR_OFF_RES_HIGH);
    assign wr_low     = wr_hit(dp_valid_r, dp_write_r, dp_addr_r, `ATR_OFF_RES_LOW);
    assign sw_go      = wr_ctrl & hwdata_i[`ATR_CTRL_BUSY_BIT];

    // ****************************************************************
    // bus slave data phase: address phase captured for the write
    // ****************************************************************
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r  <= 12'h000;
        end else begin
            dp_valid_r <= addr_phase;
            dp_write_r <= hwrite_i;
            dp_addr_r  <= haddr_i;
        end
    end

    // ****************************************************************
    // bus slave response: zero wait states, okay always
    // ****************************************************************
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // ****************************************************************
    // read data: sampled at the address phase, stands until the next read
    // ****************************************************************
    always @* begin
        rd_nxt = hrdata_o;
        if (addr_phase & ~hwrite_i) begin
            rd_nxt = rd_view(haddr_i, trig_sel_r, res_high_r, res_low_r, justify_r,
                             conv_busy_o);
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hrdata_o <= 32'h0000_0000;
        end else begin
            hrdata_o <= rd_nxt;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    always @* begin
        trig_sel_nxt = trig_sel_r;
        justify_nxt  = justify_r;
        if (wr_sel) begin
            trig_sel_nxt = hwdata_i[`ATR_TRIG_SEL_MSB:0];
        end
        if (wr_ctrl) begin
            justify_nxt = hwdata_i[`ATR_CTRL_JUSTIFY_BIT];
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trig_sel_r <= `ATR_TRIG_SEL_RST;
            justify_r  <= `ATR_JUSTIFY_RST;
        end else begin
            trig_sel_r <= trig_sel_nxt;
            justify_r  <= justify_nxt;
        end
    end

    // ****************************************************************
    // conversion handshake
    // ****************************************************************
    // a start while busy is dropped, so an edge during a conversion is lost
    assign start_now = ~conv_busy_o & (sw_go | trig_edge);
    assign conv_load = conv_busy_o & conv_done_i;

    always @* begin
        start_nxt = start_now;
        busy_nxt  = conv_busy_o;
        if (start_now) begin
            busy_nxt = 1'b1;
        end else if (conv_done_i) begin
            busy_nxt = 1'b0;
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_busy_o  <= 1'b0;
            conv_start_o <= 1'b0;
        end else begin
            conv_busy_o  <= busy_nxt;
            conv_start_o <= start_nxt;
        end
    end

    // ****************************************************************
    // result registers: no reset, keep contents across resets
    // ****************************************************************
    // a finishing conversion wins over a software write in the same cycle
    always @* begin
        res_high_nxt = res_high_r;
        res_low_nxt  = res_low_r;
        if (conv_load) begin
            res_high_nxt = fmt_high(justify_r, conv_value_i);
            res_low_nxt  = fmt_low(justify_r, conv_value_i);
        end else begin
            if (wr_high) begin
                res_high_nxt = hwdata_i[7:0];
            end
            if (wr_low) begin
                res_low_nxt = hwdata_i[7:0];
            end
        end
    end

    always @(posedge clk_i) begin
        res_high_r <= res_high_nxt;
        res_low_r  <= res_low_nxt;
    end

endmodule // atr_trigger_result
`default_nettype wire

// [dv/atr_conv_model.sv]
// atr_conv_model.sv: converter core answering a start with a done pulse after lat_i cycles
// assumes lat_i of at least one; the result line is scrambled outside done
`timescale 1ns/1ps
`default_nettype none
module atr_conv_model (
    input  wire logic       clk_i,   // system clock
    input  wire logic       rst_b_i, // reset, active low
    input  wire logic [3:0] lat_i,   // conversion length in cycles
    input  wire logic       start_i, // start pulse
    input  wire logic [9:0] value_i, // value to return
    output logic            done_o,  // one-cycle done pulse
    output logic      [9:0] result_o // result, valid with done
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 4'h0;
        end else if (start_i) begin
            cnt_r <= lat_i;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    assign done_o = (cnt_r == 4'h1);
    assign result_o = done_o ? value_i : ~value_i;
endmodule // atr_conv_model
`default_nettype wire

// [dv/atr_trigger_result_asserts.sv]
// atr_trigger_result_asserts.sv: port checks of starts, busy flag and bus answer
// assumes only the top module's ports; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module atr_trigger_result_asserts (
    input wire        clk_i,        // system clock
    input wire        rst_b_i,      // reset, active low
    input wire        hsel_i,       // slave select
    input wire [11:0] haddr_i,      // byte address
    input wire [1:0]  htrans_i,     // transfer type
    input wire        hwrite_i,     // write when high
    input wire [31:0] hwdata_i,     // write data
    input wire        hreadyout_o,  // slave ready
    input wire        hresp_o,      // response
    input wire        conv_done_i,  // converter finished
    input wire        conv_start_o, // start pulse
    input wire        conv_busy_o   // conversion in progress
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_ready_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    chk_start_busy: assert property (conv_start_o |-> conv_busy_o)
        else $error("start without busy");
    chk_start_single: assert property (conv_start_o |=> !conv_start_o)
        else $error("start longer than one cycle");
    chk_start_idle: assert property (conv_start_o |-> !$past(conv_busy_o))
        else $error("start while busy");
    chk_busy_rise: assert property ($rose(conv_busy_o) |-> conv_start_o)
        else $error("busy rose without start");
    chk_busy_hold: assert property (conv_busy_o && !conv_done_i |=> conv_busy_o)
        else $error("busy dropped before done");
    chk_busy_clear: assert property (conv_busy_o && conv_done_i |=> !conv_busy_o)
        else $error("busy kept after done");
    chk_sw_start: assert property (hsel_i && htrans_i[1] && hwrite_i && haddr_i == 12'h00C
        && !conv_busy_o ##1 hwdata_i[0] && !conv_busy_o |=> conv_start_o)
        else $error("software start missed");
endmodule // atr_trigger_result_asserts
bind atr_trigger_result atr_trigger_result_asserts atr_trigger_result_asserts_i (.clk_i,
    .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hreadyout_o, .hresp_o,
    .conv_done_i, .conv_start_o, .conv_busy_o);
`default_nettype wire

// [dv/tb.sv]
// tb.sv: self-checking bench for trigger selection and result formatting
// assumes a 100 MHz clock and the converter model on the far side
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, done;
    logic [11:0] haddr_i = 12'h000;
    logic [1:0]  htrans_i = 2'h0;
    logic [31:0] hwdata_i = 32'h0, hrdata_o, rd;
    logic [8:0]  src = 9'h000;
    logic [9:0]  val = 10'h000, res;
    logic        hreadyout_o, hresp_o, conv_start_o, conv_busy_o;
    int          n_mismatch = 0, checked = 0, n_start = 0, cyc = 0;
    logic [3:0]  codes [10] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hC, 4'hD, 4'h0};
    atr_trigger_result atr_trigger_result_i (.clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
        .hresp_o, .tmr0_ovf_i(src[0]), .tmr1_ovf_i(src[1]), .tmr2_per_i(src[2]),
        .cmp1_i(src[3]), .cmp2_i(src[4]), .lc1_i(src[5]), .lc2_i(src[6]), .cc1_i(src[7]),
        .cc2_i(src[8]), .conv_done_i(done), .conv_value_i(res), .conv_start_o, .conv_busy_o);
    atr_conv_model atr_conv_model_i (.clk_i, .rst_b_i, .lat_i(4'h5), .start_i(conv_start_o),
        .value_i(val), .done_o(done), .result_o(res));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        n_start <= n_start + int'(conv_start_o === 1'b1);
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    // ****************************************
    // selected source starts once, others and held levels do not
    // ****************************************
    task automatic trig_case(input logic [3:0] code, input int idx, input logic j,
                             input logic [9:0] v);
        int          s0;
        logic [15:0] e;
        e = j ? {6'h00, v} : {v, 6'h00};
        bus(12'h00C, 1'b1, {30'h0, j, 1'b0});
        bus(12'h000, 1'b1, {28'h0, code});
        val <= v;
        s0 = n_start;
        src <= ~(9'h001 << idx);
        repeat (3) @(posedge clk_i);
        src <= 9'h1FF;
        repeat (14) @(posedge clk_i);
        chk("start count", n_start - s0, {31'h0, code != 4'h0});
        chk("busy after done", conv_busy_o, 32'h0);
        if (code != 4'h0) begin
            bus(12'h004, 1'b0, 32'h0);
            chk("result high", rd, {24'h0, e[15:8]});
            bus(12'h008, 1'b0, 32'h0);
            chk("result low", rd, {24'h0, e[7:0]});
        end
        src <= 9'h000;
    endtask
    task automatic sw_case();
        int s0;
        bus(12'h004, 1'b1, 32'h0000_01A5);
        bus(12'h004, 1'b0, 32'h0);
        chk("high written", rd, 32'h0000_00A5);
        val <= 10'h2C3;
        s0 = n_start;
        bus(12'h00C, 1'b1, 32'h0000_0003);
        bus(12'h00C, 1'b1, 32'h0000_0003);
        repeat (10) @(posedge clk_i);
        chk("software starts", n_start - s0, 32'h1);
        bus(12'h010, 1'b0, 32'h0);
        chk("combined view", rd, 32'h0000_02C3);
        bus(12'h000, 1'b1, 32'h0000_0006);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        bus(12'h000, 1'b0, 32'h0);
        chk("select after reset", rd, 32'h0);
        bus(12'h00C, 1'b0, 32'h0);
        chk("control after reset", rd, 32'h0);
        bus(12'h008, 1'b0, 32'h0);
        chk("low kept", rd, 32'h0000_00C3);
        bus(12'h020, 1'b1, 32'hFFFF_FFFF);
        bus(12'h020, 1'b0, 32'h0);
        chk("unmapped", rd, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        bus(12'h00C, 1'b0, 32'h0);
        chk("control reset", rd, 32'h0);
        for (int i = 0; i < 10; i++) begin
            trig_case(codes[i], i, i[0], 10'h2B5 ^ (10'h003 << i));
        end
        sw_case();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
